// ===== rtl/tmc_timer_regs.vh
// Constants for the three-channel down timer with channel 2 capture.
// Assumes byte addresses on an 8-bit register port with 32-bit data words.
// Notes on behaviour
// - Channel 2 control bit 9 is the capture flag; write 0 clears, 1 ignored.
// - Channel 2 has a 32-bit read-only capture value register; writes ignored.
// - Capture copies channel 2 counter only while capture flag is 0.
// - Capture value survives every reset and standby; never reinitialised.
// - Each channel has a 32-bit down counter and 32-bit reload constant.
// - A channel counts down once its run bit in the shared register is 1.
// - Underflow sets the underflow flag and reloads the counter in one step.
// - Underflow interrupt equals underflow flag AND underflow interrupt enable.
// - Capture interrupt asserts when capture flag is 1 and capture control is 11.
// - Internal count clocks are peripheral clock divided by 4, 16, 64, 256, 1024.
// - External timer pin may clock the counter on rising, falling or both edges.
// - The real-time clock output may serve as the count clock.
// - Edge select picks which pin edge triggers capture of channel 2.
// - Capture does nothing while the device is in standby.
// - No new DMA request until the previous one has been serviced.
// - Four interrupt sources, priority: underflow 0, 1, 2, then capture 2.
// - Capture control: 00 off, 01 reserved, 10 capture, 11 capture with irq and DMA.
// - Underflow flag is control bit 8; write 0 clears, write 1 ignored.
// - Edge select 00 rising, 01 falling, 1x both edges.
`ifndef TMC_TIMER_REGS_VH
`define TMC_TIMER_REGS_VH

// Register map
`define TMC_ADDR_RUN    8'h04
`define TMC_CH0_BASE    8
`define TMC_CH_STRIDE   12
`define TMC_OFS_RELOAD  8'h00
`define TMC_OFS_COUNT   8'h04
`define TMC_OFS_CTRL    8'h08
`define TMC_ADDR_CTRL2  8'h28
`define TMC_ADDR_CAPT   8'h2C

// Control register fields
`define TMC_F_CKSEL     2:0
`define TMC_F_EDGE      4:3
`define TMC_F_UIE       5
`define TMC_F_CAPC      7:6
`define TMC_F_CFG       7:0
`define TMC_F_UF        8
`define TMC_F_CF        9

// Reset values
`define TMC_CFG_RST     8'h00
`define TMC_CNT_RST     32'hFFFFFFFF
`define TMC_RUN_RST     3'h0

// Clock select codes, 0 to 4 are the prescaler taps
`define TMC_CK_RTC      3'h5
`define TMC_CK_EXT0     3'h6
`define TMC_CK_EXT1     3'h7

// Edge select and capture control codes
`define TMC_EDGE_RISE   2'h0
`define TMC_EDGE_FALL   2'h1
`define TMC_EDGE_BOTH_B 1
`define TMC_CAP_OFF     2'h0
`define TMC_CAP_NOIRQ   2'h2
`define TMC_CAP_IRQ     2'h3
`define TMC_CAP_ON_B    1

// Prescaler and interrupt source codes
`define TMC_PS_W        10
`define TMC_PS_TAPS     5
`define TMC_SRC_NONE    3'h0
`define TMC_SRC_UF0     3'h1
`define TMC_SRC_UF1     3'h2
`define TMC_SRC_UF2     3'h3
`define TMC_SRC_CAP2    3'h4

`endif

// ===== rtl/tmc_prescale.v
// Free-running prescaler giving one-cycle ticks at clock/4, /16, /64, /256, /1024.
// Assumes the peripheral clock is clk_i and the parent gates nothing else.
`timescale 1ns/1ns
`include "tmc_timer_regs.vh"

module tmc_prescale (
	// Clock, reset, enable
	input  wire                     clk_i,
	input  wire                     rst_b_i,
	input  wire                     ce_i,
	// Tick outputs, bit k divides by 4 to the k+1
	output wire [`TMC_PS_TAPS-1:0]  tick_o
);

	reg  [`TMC_PS_W-1:0] div_ff;

	// Divider counter
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_ff <= {`TMC_PS_W{1'b0}};
		end else if (ce_i) begin
			div_ff <= div_ff + 1'b1;
		end
	end

	// One tap per division ratio
	genvar k;
	generate
		for (k = 0; k < `TMC_PS_TAPS; k = k + 1) begin : g_tap
			assign tick_o[k] = ce_i & (&div_ff[2*k+1:0]);
		end
	endgenerate

endmodule // tmc_prescale

// ===== rtl/tmc_edge_sync.v
// Two-flop synchroniser with rise and fall pulse detection.
// Assumes the input is asynchronous to clk_i and slower than clk_i/4.
`timescale 1ns/1ns

module tmc_edge_sync (
	// Clock, reset, enable
	input  wire clk_i,
	input  wire rst_b_i,
	input  wire ce_i,
	// Asynchronous level in, edge pulses out
	input  wire async_i,
	output wire rise_o,
	output wire fall_o
);

	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	// Synchroniser chain plus history flop
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else if (ce_i) begin
			s1_ff <= async_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Edge pulses from synchronised samples only
	assign rise_o = ce_i & s2_ff & ~s3_ff;
	assign fall_o = ce_i & ~s2_ff & s3_ff;

endmodule // tmc_edge_sync

// ===== rtl/tmc_timer_top.v
// Three-channel 32-bit down timer with auto-reload and channel 2 input capture.
// Assumes a single 25 MHz clock, standby_i and dma_done_i from same-clock logic,
// and the timer pin and RTC output arriving asynchronously.
`timescale 1ns/1ns
`include "tmc_timer_regs.vh"

module tmc_timer_top (
	// Clock, reset, enable
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        ce_i,
	// Register port
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output wire [31:0] rdata_o,
	// Pins and system inputs
	input  wire        ext_timer_pin_i,
	input  wire        rtc_clk_i,
	input  wire        standby_i,
	input  wire        dma_done_i,
	// Requests to interrupt and DMA controllers
	output wire        underflow_irq_ch0_o,
	output wire        underflow_irq_ch1_o,
	output wire        underflow_irq_ch2_o,
	output wire        capture_irq_ch2_o,
	output wire [2:0]  irq_source_o,
	output wire        dma_req_o
);

	// Shared run register and channel state
	reg  [2:0]                run_ff;
	reg  [31:0]               rdata_ff;
	reg                       capture_flag_ff;
	reg  [31:0]               capture_value_ch2_ff;
	reg                       dma_req_ff;
	reg  [2:0]                uf_irq_ff;
	reg                       cap_irq_ff;
	reg  [2:0]                irq_src_ff;
	wire [95:0]               cnt_all;
	wire [95:0]               rel_all;
	wire [23:0]               cfg_all;
	wire [2:0]                uf_all;
	wire [`TMC_PS_TAPS-1:0]   ps_tick;
	wire                      pin_rise;
	wire                      pin_fall;
	wire                      rtc_rise;

	// Prescaler taps
	tmc_prescale u_prescale (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.tick_o  (ps_tick)
	);

	// External timer pin edges
	tmc_edge_sync u_pin_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.async_i (ext_timer_pin_i),
		.rise_o  (pin_rise),
		.fall_o  (pin_fall)
	);

	// Real-time clock output edges
	tmc_edge_sync u_rtc_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.async_i (rtc_clk_i),
		.rise_o  (rtc_rise),
		.fall_o  ()
	);

	// Shared run register write
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			run_ff <= `TMC_RUN_RST;
		end else if (ce_i && wr_i && addr_i == `TMC_ADDR_RUN) begin
			run_ff <= wdata_i[2:0];
		end
	end

	// Per-channel counter, reload constant and control
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_ch
			localparam integer BASE_I = `TMC_CH0_BASE + i * `TMC_CH_STRIDE;
			localparam [7:0]   BASE   = BASE_I[7:0];
			reg  [31:0] down_counter_ff;
			reg  [31:0] reload_constant_ff;
			reg  [7:0]  cfg_ff;
			reg         underflow_flag_ff;
			reg         tick;
			wire [7:0]  a_rel   = addr_i - BASE;
			wire        wr_cnt  = wr_i && a_rel == `TMC_OFS_COUNT;
			wire        wr_rel  = wr_i && a_rel == `TMC_OFS_RELOAD;
			wire        wr_ctl  = wr_i && a_rel == `TMC_OFS_CTRL;
			wire [1:0]  edge_sel = cfg_ff[`TMC_F_EDGE];
			wire        pin_ev;
			wire        uf_ev;

			// Pin edge qualified by edge select
			assign pin_ev = edge_sel[`TMC_EDGE_BOTH_B] ? (pin_rise | pin_fall) :
				(edge_sel == `TMC_EDGE_FALL) ? pin_fall : pin_rise;

			// Count event source by clock select
			always @* begin
				case (cfg_ff[`TMC_F_CKSEL])
					3'h0: tick = ps_tick[0];
					3'h1: tick = ps_tick[1];
					3'h2: tick = ps_tick[2];
					3'h3: tick = ps_tick[3];
					3'h4: tick = ps_tick[4];
					`TMC_CK_RTC: tick = rtc_rise;
					`TMC_CK_EXT0: tick = pin_ev;
					`TMC_CK_EXT1: tick = pin_ev;
					default: tick = 1'b0;
				endcase
			end

			// Underflow is a tick while the counter holds zero
			assign uf_ev = run_ff[i] & tick & (down_counter_ff == 32'h00000000);

			// Counter and reload constant
			always @(posedge clk_i) begin
				if (!rst_b_i) begin
					down_counter_ff    <= `TMC_CNT_RST;
					reload_constant_ff <= `TMC_CNT_RST;
				end else if (ce_i) begin
					if (wr_rel) begin
						reload_constant_ff <= wdata_i;
					end
					if (wr_cnt) begin
						down_counter_ff <= wdata_i;
					end else if (uf_ev) begin
						down_counter_ff <= reload_constant_ff;
					end else if (run_ff[i] && tick) begin
						down_counter_ff <= down_counter_ff - 32'h00000001;
					end
				end
			end

			// Control fields and underflow flag, set wins over clear
			always @(posedge clk_i) begin
				if (!rst_b_i) begin
					cfg_ff            <= `TMC_CFG_RST;
					underflow_flag_ff <= 1'b0;
				end else if (ce_i) begin
					if (wr_ctl) begin
						cfg_ff <= wdata_i[`TMC_F_CFG];
					end
					if (uf_ev) begin
						underflow_flag_ff <= 1'b1;
					end else if (wr_ctl && !wdata_i[`TMC_F_UF]) begin
						underflow_flag_ff <= 1'b0;
					end
				end
			end

			assign cnt_all[32*i +: 32] = down_counter_ff;
			assign rel_all[32*i +: 32] = reload_constant_ff;
			assign cfg_all[8*i +: 8]   = cfg_ff;
			assign uf_all[i]           = underflow_flag_ff;
		end
	endgenerate

	// Channel 2 capture qualifiers
	wire [7:0]  cfg2     = cfg_all[23:16];
	wire [1:0]  capc2    = cfg2[`TMC_F_CAPC];
	wire [1:0]  edge2    = cfg2[`TMC_F_EDGE];
	wire        cap_on   = capc2 == `TMC_CAP_NOIRQ || capc2 == `TMC_CAP_IRQ;
	wire        cap_edge = edge2[`TMC_EDGE_BOTH_B] ? (pin_rise | pin_fall) :
		(edge2 == `TMC_EDGE_FALL) ? pin_fall : pin_rise;
	wire        cap_ev   = cap_on & ~standby_i & cap_edge;
	wire        wr_ctl2  = wr_i && addr_i == `TMC_ADDR_CTRL2;

	// Capture flag, set on every qualifying edge and wins over clear
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			capture_flag_ff <= 1'b0;
		end else if (ce_i) begin
			if (cap_ev) begin
				capture_flag_ff <= 1'b1;
			end else if (wr_ctl2 && !wdata_i[`TMC_F_CF]) begin
				capture_flag_ff <= 1'b0;
			end
		end
	end

	// Capture value, deliberately outside every reset
	always @(posedge clk_i) begin
		if (ce_i && cap_ev && !capture_flag_ff) begin
			capture_value_ch2_ff <= cnt_all[95:64];
		end
	end

	// DMA request held until serviced, no overlap
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			dma_req_ff <= 1'b0;
		end else if (ce_i) begin
			if (dma_req_ff) begin
				if (dma_done_i) begin
					dma_req_ff <= 1'b0;
				end
			end else if (cap_ev && capc2 == `TMC_CAP_IRQ) begin
				dma_req_ff <= 1'b1;
			end
		end
	end

	// Interrupt requests and highest pending source
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			uf_irq_ff  <= 3'h0;
			cap_irq_ff <= 1'b0;
			irq_src_ff <= `TMC_SRC_NONE;
		end else if (ce_i) begin
			uf_irq_ff  <= uf_all & {cfg_all[16+`TMC_F_UIE], cfg_all[8+`TMC_F_UIE], cfg_all[`TMC_F_UIE]};
			cap_irq_ff <= capture_flag_ff & (capc2 == `TMC_CAP_IRQ);
			if (uf_irq_ff[0]) begin
				irq_src_ff <= `TMC_SRC_UF0;
			end else if (uf_irq_ff[1]) begin
				irq_src_ff <= `TMC_SRC_UF1;
			end else if (uf_irq_ff[2]) begin
				irq_src_ff <= `TMC_SRC_UF2;
			end else if (cap_irq_ff) begin
				irq_src_ff <= `TMC_SRC_CAP2;
			end else begin
				irq_src_ff <= `TMC_SRC_NONE;
			end
		end
	end

	// Read mux, channel index and word offset from the address
	reg  [31:0] rd_mux;
	wire [7:0]  a_ch = addr_i - `TMC_CH0_BASE;
	always @* begin
		rd_mux = 32'h00000000;
		if (addr_i == `TMC_ADDR_RUN) begin
			rd_mux = {29'h00000000, run_ff};
		end else if (addr_i == `TMC_ADDR_CAPT) begin
			rd_mux = capture_value_ch2_ff;
		end else begin
			case (a_ch)
				8'h00: rd_mux = rel_all[31:0];
				8'h04: rd_mux = cnt_all[31:0];
				8'h08: rd_mux = {23'h000000, uf_all[0], cfg_all[7:0]};
				8'h0C: rd_mux = rel_all[63:32];
				8'h10: rd_mux = cnt_all[63:32];
				8'h14: rd_mux = {23'h000000, uf_all[1], cfg_all[15:8]};
				8'h18: rd_mux = rel_all[95:64];
				8'h1C: rd_mux = cnt_all[95:64];
				8'h20: rd_mux = {22'h000000, capture_flag_ff, uf_all[2], cfg_all[23:16]};
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// Read data stands one cycle after the strobe
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			rdata_ff <= 32'h00000000;
		end else if (ce_i) begin
			rdata_ff <= rd_i ? rd_mux : 32'h00000000;
		end
	end

	assign rdata_o             = rdata_ff;
	assign underflow_irq_ch0_o = uf_irq_ff[0];
	assign underflow_irq_ch1_o = uf_irq_ff[1];
	assign underflow_irq_ch2_o = uf_irq_ff[2];
	assign capture_irq_ch2_o   = cap_irq_ff;
	assign irq_source_o        = irq_src_ff;
	assign dma_req_o           = dma_req_ff;

endmodule // tmc_timer_top

// ===== bench/tmc_timer_checker.sv
// Port-level assertions for the three-channel down timer with capture.
// Assumes it is bound onto tmc_timer_top and sees only that module's ports.
`timescale 1ns/1ns
module tmc_timer_checker (
	// Clock, reset, enable
	input wire        clk_i,
	input wire        rst_b_i,
	input wire        ce_i,
	// Register port
	input wire [7:0]  addr_i,
	input wire [31:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [31:0] rdata_o,
	// Pins and system inputs
	input wire        ext_timer_pin_i,
	input wire        rtc_clk_i,
	input wire        standby_i,
	input wire        dma_done_i,
	// Requests
	input wire        underflow_irq_ch0_o,
	input wire        underflow_irq_ch1_o,
	input wire        underflow_irq_ch2_o,
	input wire        capture_irq_ch2_o,
	input wire [2:0]  irq_source_o,
	input wire        dma_req_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Pending interrupt lines, lowest index wins
	wire [3:0] pend = {capture_irq_ch2_o, underflow_irq_ch2_o, underflow_irq_ch1_o, underflow_irq_ch0_o};

	prio_uf0_a: assert property ($past(ce_i) && $past(pend[0]) |-> irq_source_o == 3'h1)
		else $error("source not uf0");
	prio_uf1_a: assert property ($past(ce_i) && $past(pend[1:0]) == 2'h2 |-> irq_source_o == 3'h2)
		else $error("source not uf1");
	prio_uf2_a: assert property ($past(ce_i) && $past(pend[2:0]) == 3'h4 |-> irq_source_o == 3'h3)
		else $error("source not uf2");
	prio_cap_a: assert property ($past(ce_i) && $past(pend) == 4'h8 |-> irq_source_o == 3'h4)
		else $error("source not capture");
	src_none_a: assert property ($past(ce_i) && $past(pend) == 4'h0 |-> irq_source_o == 3'h0)
		else $error("source without request");
	rdata_idle_a: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside read slot");
	dma_hold_a: assert property (ce_i && dma_req_o && !dma_done_i |=> dma_req_o)
		else $error("dma request dropped early");
	dma_drop_a: assert property (ce_i && dma_req_o && dma_done_i |=> !dma_req_o)
		else $error("dma request held after done");
	dma_standby_a: assert property ($rose(dma_req_o) |-> !$past(standby_i))
		else $error("capture request in standby");
	cap_irq_a: assert property (ce_i && $rose(dma_req_o) |=> capture_irq_ch2_o)
		else $error("capture irq missing");
endmodule // tmc_timer_checker

// ===== bench/tmc_dma_partner.sv
// Behavioural DMA controller answering channel 2 capture requests.
// Assumes dma_req_i is a level held until the done pulse is seen.
`timescale 1ns/1ns
module tmc_dma_partner (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_b_i,
	// Request in, service speed select
	input  wire       dma_req_i,
	input  wire       slow_i,
	// Completion pulse and request tally
	output wire       dma_done_o,
	output wire [7:0] req_count_o
);
	reg       seen_ff;
	reg       done_ff;
	reg [7:0] wait_ff;
	reg [7:0] count_ff;
	assign dma_done_o  = done_ff;
	assign req_count_o = count_ff;
	// Count new requests, answer after a prompt or slow delay
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			seen_ff <= 1'b0;
			done_ff <= 1'b0;
			wait_ff <= 8'h00;
			count_ff <= 8'h00;
		end else begin
			seen_ff <= dma_req_i;
			done_ff <= 1'b0;
			if (dma_req_i && !seen_ff) begin
				count_ff <= count_ff + 8'h01;
				wait_ff <= slow_i ? 8'h64 : 8'h02;
			end else if (wait_ff == 8'h01) begin
				done_ff <= 1'b1;
				wait_ff <= 8'h00;
			end else if (wait_ff != 8'h00) begin
				wait_ff <= wait_ff - 8'h01;
			end
		end
	end
endmodule // tmc_dma_partner

// ===== bench/tmc_timer_tb_top.sv
// Self-checking bench for the three-channel down timer with capture.
// Assumes the design, the checker and the DMA partner are compiled first.
`timescale 1ns/1ns
`include "tmc_timer_regs.vh"
module tmc_timer_tb_top;
	reg         clk_i = 1'b0;
	reg         rst_b_i = 1'b0;
	reg         ce_i = 1'b1;
	reg  [7:0]  addr_i = 8'h00;
	reg  [31:0] wdata_i = 32'h0;
	reg         wr_i = 1'b0;
	reg         rd_i = 1'b0;
	reg         ext_timer_pin_i = 1'b0;
	reg         rtc_clk_i = 1'b0;
	reg         standby_i = 1'b0;
	reg         dma_slow = 1'b0;
	wire [31:0] rdata_o;
	wire        dma_done_i;
	wire        dma_req_o;
	wire        uf0, uf1, uf2, cap_irq;
	wire [2:0]  irq_source_o;
	wire [7:0]  req_count;
	wire [4:0]  mon = {dma_req_o, cap_irq, uf2, uf1, uf0};
	integer     err_count = 0;
	integer     cmp_count = 0;
	integer     k, e;
	reg  [31:0] seed = 32'h2C4F1442;
	reg  [31:0] v1, v2, got, w;
	time        t1;

	tmc_timer_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_timer_pin_i(ext_timer_pin_i), .rtc_clk_i(rtc_clk_i),
		.standby_i(standby_i), .dma_done_i(dma_done_i), .underflow_irq_ch0_o(uf0), .underflow_irq_ch1_o(uf1),
		.underflow_irq_ch2_o(uf2), .capture_irq_ch2_o(cap_irq), .irq_source_o(irq_source_o), .dma_req_o(dma_req_o));
	tmc_dma_partner dma (.clk_i(clk_i), .rst_b_i(rst_b_i), .dma_req_i(dma_req_o), .slow_i(dma_slow),
		.dma_done_o(dma_done_i), .req_count_o(req_count));

	// 25 MHz clock
	always #20 clk_i = ~clk_i;

	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [7:0] ch_addr(input integer c, input integer o);
		ch_addr = 8'(8 + 12 * c + o);
	endfunction
	function [31:0] period(input integer p, input [31:0] r);
		period = (r + 32'h1) << (2 * p + 2);
	endfunction
	task check(input [31:0] g, input [31:0] x);
		begin
			cmp_count = cmp_count + 1;
			if (g !== x) begin
				err_count = err_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			wr_i <= 1'b1;
			addr_i <= a;
			wdata_i <= d;
			@(posedge clk_i);
			wr_i <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clk_i);
			rd_i <= 1'b1;
			addr_i <= a;
			@(posedge clk_i);
			rd_i <= 1'b0;
			@(negedge clk_i);
			got = rdata_o;
		end
	endtask
	task wait_mon(input integer idx, input lvl);
		integer n;
		begin
			n = 0;
			while (mon[idx] !== lvl && n < 10000) begin
				@(negedge clk_i);
				n = n + 1;
			end
			if (n == 10000) err_count = err_count + 1;
		end
	endtask
	task pulse(input which, input lvl);
		begin
			@(posedge clk_i);
			if (which) rtc_clk_i <= lvl;
			else ext_timer_pin_i <= lvl;
			repeat (8) @(posedge clk_i);
		end
	endtask
	task tally_and_finish;
		begin
			if (err_count == 0 && cmp_count > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask

	// Hang guard
	initial begin
		#(40 * 60000);
		err_count = err_count + 1;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (k = 0; k < 3; k = k + 1) begin
			rd(ch_addr(k, 4)); check(got, 32'hFFFFFFFF);
			rd(ch_addr(k, 8)); check(got, 32'h0);
		end
		rd(8'h3C); check(got, 32'h0);
		// Underflow period on every prescaler tap
		for (k = 0; k < 5; k = k + 1) begin
			seed = lfsr(seed);
			v1 = {30'h0, seed[1:0]} + 32'h2;
			wr(ch_addr(k % 3, 8), 32'h20 | k);
			wr(ch_addr(k % 3, 0), v1);
			wr(ch_addr(k % 3, 4), 32'h0);
			wr(`TMC_ADDR_RUN, 32'h1 << (k % 3));
			wait_mon(k % 3, 1'b1);
			t1 = $time;
			@(negedge clk_i);
			check({29'h0, irq_source_o}, (k % 3) + 1);
			wr(ch_addr(k % 3, 8), 32'h20 | k);
			wait_mon(k % 3, 1'b0);
			wait_mon(k % 3, 1'b1);
			check(32'(($time - t1) / 40), period(k, v1));
			wr(`TMC_ADDR_RUN, 32'h0);
			wr(ch_addr(k % 3, 8), 32'h100 | k);
			rd(ch_addr(k % 3, 8)); check(got, 32'h100 | k);
			check({31'h0, mon[k % 3]}, 32'h0);
			wr(ch_addr(k % 3, 8), 32'h0);
		end
		// Pin edges and RTC as count clock on channel 1
		for (e = 0; e < 4; e = e + 1) begin
			wr(ch_addr(1, 8), e < 3 ? (e << 3) | 6 : 5);
			wr(ch_addr(1, 4), 32'h0A);
			wr(`TMC_ADDR_RUN, 32'h2);
			repeat (3) begin
				pulse(e == 3, 1'b1);
				pulse(e == 3, 1'b0);
			end
			wr(`TMC_ADDR_RUN, 32'h0);
			rd(ch_addr(1, 4)); check(got, (e == 2) ? 32'h4 : 32'h7);
		end
		// Capture with a slow DMA partner
		seed = lfsr(seed);
		v1 = seed;
		seed = lfsr(seed);
		v2 = seed;
		dma_slow = 1'b1;
		wr(ch_addr(2, 4), v1);
		wr(`TMC_ADDR_CTRL2, 32'hC0);
		pulse(0, 1'b1);
		pulse(0, 1'b0);
		rd(`TMC_ADDR_CTRL2); check(got, 32'h2C0);
		check({31'h0, cap_irq}, 32'h1);
		rd(`TMC_ADDR_CAPT); check(got, v1);
		wr(ch_addr(2, 4), v2);
		wr(`TMC_ADDR_CAPT, v2);
		pulse(0, 1'b1);
		pulse(0, 1'b0);
		rd(`TMC_ADDR_CAPT); check(got, v1);
		rd(`TMC_ADDR_CTRL2); check(got, 32'h2C0);
		wait_mon(4, 1'b0);
		check({24'h0, req_count}, 32'h1);
		wr(`TMC_ADDR_CTRL2, 32'h88);
		pulse(0, 1'b1);
		rd(`TMC_ADDR_CTRL2); check(got, 32'h88);
		pulse(0, 1'b0);
		rd(`TMC_ADDR_CTRL2); check(got, 32'h288);
		rd(`TMC_ADDR_CAPT); check(got, v2);
		check({27'h0, mon}, 32'h0);
		// Off, reserved, and standby give no capture
		for (e = 0; e < 3; e = e + 1) begin
			w = e < 2 ? (e << 6) | 32'h10 : 32'hD0;
			wr(`TMC_ADDR_CTRL2, w);
			standby_i <= (e == 2);
			pulse(0, 1'b1);
			pulse(0, 1'b0);
			rd(`TMC_ADDR_CTRL2); check(got, w);
		end
		@(posedge clk_i);
		standby_i <= 1'b0;
		dma_slow = 1'b0;
		seed = lfsr(seed);
		wr(ch_addr(2, 4), seed);
		pulse(0, 1'b1);
		pulse(0, 1'b0);
		rd(`TMC_ADDR_CAPT); check(got, seed);
		wait_mon(4, 1'b0);
		check({24'h0, req_count}, 32'h3);
		// Capture value survives a reset
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(`TMC_ADDR_CAPT); check(got, seed);
		rd(`TMC_ADDR_CTRL2); check(got, 32'h0);
		// Clock enable low freezes state, so a write then is lost
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(ch_addr(0, 0), seed);
		ce_i <= 1'b1;
		rd(ch_addr(0, 0)); check(got, 32'hFFFFFFFF);
		tally_and_finish;
	end
endmodule // tmc_timer_tb_top

bind tmc_timer_top tmc_timer_checker chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_timer_pin_i(ext_timer_pin_i),
	.rtc_clk_i(rtc_clk_i), .standby_i(standby_i), .dma_done_i(dma_done_i),
	.underflow_irq_ch0_o(underflow_irq_ch0_o), .underflow_irq_ch1_o(underflow_irq_ch1_o),
	.underflow_irq_ch2_o(underflow_irq_ch2_o), .capture_irq_ch2_o(capture_irq_ch2_o),
	.irq_source_o(irq_source_o), .dma_req_o(dma_req_o));
